// >>> src/ebm_defs.svh
// named constants of the embedded block memory: widths, capacity, reset values
// assumes inclusion by the package and by every design module that needs numbers
`ifndef EBM_DEFS_SVH
`define EBM_DEFS_SVH
// total storage bits of one block
`define EBM_CAPACITY_BITS 18432
// default port shape, 1024 words of 18 bits
`define EBM_DEF_DATA_W 18
`define EBM_DEF_ADDR_W 10
// widths that allow read-before-write
`define EBM_RBW_W0 9
`define EBM_RBW_W1 18
`define EBM_RBW_W2 36
// value of a cleared output latch or output register
`define EBM_OUT_CLR_VAL '0
// value of the input registers during system reset
`define EBM_IN_CLR_VAL '0
`endif

// >>> src/ebm_pkg.sv
// types shared by the memory top and its output stage
// assumes the constants header sits beside it
`include "ebm_defs.svh"
package ebm_pkg;
  // write behaviour of one port, one-hot
  typedef enum logic [2:0] {
    EBM_WM_NORMAL = 3'h1,
    EBM_WM_THROUGH = 3'h2,
    EBM_WM_RBW = 3'h4
  } ebm_wmode_t;
  // reset style of the output latches, one-hot
  typedef enum logic [1:0] {
    EBM_RST_SYNC = 2'h1,
    EBM_RST_ASYNC = 2'h2
  } ebm_rst_style_t;
  // access strobes of one port
  typedef struct packed {
    logic en; // port takes part this cycle
    logic we; // access is a write
  } ebm_ctl_t;
  // true when read-before-write is legal for a width
  function automatic logic ebm_rbw_ok(input int width);
    ebm_rbw_ok = (width == `EBM_RBW_W0) || (width == `EBM_RBW_W1) ||
                 (width == `EBM_RBW_W2);
  endfunction : ebm_rbw_ok
endpackage : ebm_pkg

// >>> src/ebm_out_stage.sv
// output latch and optional output register of one memory port
// assumes the array word and the registered strobes come from the top
`include "ebm_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module ebm_out_stage
  import ebm_pkg::*;
#(
  parameter int DATA_W = `EBM_DEF_DATA_W,
  parameter ebm_wmode_t WMODE = EBM_WM_NORMAL,
  parameter bit OUT_REG = 1'b0,
  parameter ebm_rst_style_t RST_STYLE = EBM_RST_SYNC
) (
  input wire logic clk_in, // port clock
  input wire logic rst_b_in, // system reset, synchronous, low
  input wire logic port_rst_in, // this port's output reset, high
  input wire logic gsr_n_in, // global reset, low
  input wire logic acc_in, // registered access enable
  input wire logic wr_in, // registered write strobe
  input wire logic [DATA_W-1:0] wdata_in, // registered write data
  input wire logic [DATA_W-1:0] old_in, // word stored at the registered address
  output logic [DATA_W-1:0] dout_out // port read data
);
  // read-before-write falls back to normal on widths that lack it
  localparam ebm_wmode_t EFF_MODE =
    ebm_wmode_t'((WMODE == EBM_WM_RBW && !ebm_rbw_ok(DATA_W)) ? EBM_WM_NORMAL : WMODE);
  // whole state of the stage
  typedef struct packed {
    logic [DATA_W-1:0] latch; // output latch
    logic [DATA_W-1:0] oreg; // optional output register
  } ebm_ost_t;
  ebm_ost_t st_q; // current state
  ebm_ost_t st_d; // next state
  logic clr; // either reset that clears this port
  // own reset or global reset, never the other port's
  assign clr = port_rst_in | ~gsr_n_in;
  // next value of latch and output register
  always_comb begin
    st_d = st_q;
    if (acc_in) begin
      if (!wr_in) begin
        // read cycle: show the addressed word
        st_d.latch = old_in;
      end else begin
        case (EFF_MODE)
          EBM_WM_NORMAL: st_d.latch = st_q.latch;
          EBM_WM_THROUGH: st_d.latch = wdata_in;
          EBM_WM_RBW: st_d.latch = old_in;
          default: st_d.latch = st_q.latch;
        endcase
      end
    end
    // output register trails the latch by one edge
    st_d.oreg = st_q.latch;
    // sync style and system reset clear on the edge
    if (!rst_b_in || clr) begin
      st_d = `EBM_OUT_CLR_VAL;
    end
  end
  // register the state in the chosen reset style
  if (RST_STYLE == EBM_RST_ASYNC) begin : g_async
    // clear at once, without waiting for the clock
    always_ff @(posedge clk_in or posedge clr) begin
      if (clr) begin
        st_q <= `EBM_OUT_CLR_VAL;
      end else begin
        st_q <= st_d;
      end
    end
  end else begin : g_sync
    // clear lands on the next clock edge
    always_ff @(posedge clk_in) begin
      st_q <= st_d;
    end
  end
  // build-time choice of the output path, both sides are flops
  assign dout_out = OUT_REG ? st_q.oreg : st_q.latch;
endmodule : ebm_out_stage
`default_nettype wire

// >>> src/ebm_top.sv
// dual-port embedded block memory with input registers and per-port output stage
// assumes both ports are driven by fabric logic on the one system clock
`include "ebm_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module ebm_top
  import ebm_pkg::*;
#(
  // all options are static; they are never changed in operation
  parameter int DATA_W = `EBM_DEF_DATA_W,
  parameter int ADDR_W = `EBM_DEF_ADDR_W,
  parameter bit ROM_MODE = 1'b0,
  parameter ebm_wmode_t A_WMODE = EBM_WM_NORMAL,
  parameter ebm_wmode_t B_WMODE = EBM_WM_NORMAL,
  parameter bit A_OUT_REG = 1'b0,
  parameter bit B_OUT_REG = 1'b0,
  parameter ebm_rst_style_t A_RST_STYLE = EBM_RST_SYNC,
  parameter ebm_rst_style_t B_RST_STYLE = EBM_RST_SYNC
) (
  input wire logic sys_clk_in, // clock of both ports
  input wire logic rst_b_in, // system reset, synchronous, low
  input wire logic global_reset_n_in, // clears both output stages, low
  input wire logic port_a_en_in, // port a access enable
  input wire logic port_a_we_in, // port a write strobe
  input wire logic [ADDR_W-1:0] port_a_addr_in, // port a address
  input wire logic [DATA_W-1:0] port_a_wdata_in, // port a write data
  input wire logic port_a_output_reset_in, // port a output reset, high
  output logic [DATA_W-1:0] port_a_rdata_out, // port a read data
  input wire logic port_b_en_in, // port b access enable
  input wire logic port_b_we_in, // port b write strobe
  input wire logic [ADDR_W-1:0] port_b_addr_in, // port b address
  input wire logic [DATA_W-1:0] port_b_wdata_in, // port b write data
  input wire logic port_b_output_reset_in, // port b output reset, high
  output logic [DATA_W-1:0] port_b_rdata_out // port b read data
);
  localparam int DEPTH = 1 << ADDR_W; // words in the array

  // registered request of one port at the array input
  typedef struct packed {
    ebm_ctl_t ctl; // enable and write strobe
    logic [ADDR_W-1:0] addr; // word address
    logic [DATA_W-1:0] wdata; // word to write
  } ebm_inreg_t;
  // whole state of the top apart from the array
  typedef struct packed {
    ebm_inreg_t a; // port a input registers
    ebm_inreg_t b; // port b input registers
  } ebm_st_t;

  ebm_st_t st_q; // current state
  ebm_st_t st_d; // next state
  logic [DATA_W-1:0] mem [DEPTH]; // storage array, not touched by resets
  logic [DATA_W-1:0] rd_a; // word at port a registered address
  logic [DATA_W-1:0] rd_b; // word at port b registered address

  // capture requests at the array input; rom mode never writes
  always_comb begin
    st_d.a.ctl.en = port_a_en_in;
    st_d.a.ctl.we = port_a_en_in & port_a_we_in & ~ROM_MODE;
    st_d.a.addr = port_a_addr_in;
    st_d.a.wdata = port_a_wdata_in;
    st_d.b.ctl.en = port_b_en_in;
    st_d.b.ctl.we = port_b_en_in & port_b_we_in & ~ROM_MODE;
    st_d.b.addr = port_b_addr_in;
    st_d.b.wdata = port_b_wdata_in;
    // system reset drops pending requests
    if (!rst_b_in) begin
      st_d = `EBM_IN_CLR_VAL;
    end
  end

  // input register bank
  always_ff @(posedge sys_clk_in) begin
    st_q <= st_d;
  end

  // array write from registered requests; port b wins a collision
  always_ff @(posedge sys_clk_in) begin
    if (st_q.a.ctl.we) begin
      mem[st_q.a.addr] <= st_q.a.wdata;
    end
    if (st_q.b.ctl.we) begin
      mem[st_q.b.addr] <= st_q.b.wdata;
    end
  end

  // array read, old contents seen by the output stages
  assign rd_a = mem[st_q.a.addr];
  assign rd_b = mem[st_q.b.addr];

  // port a output stage, cleared by its own or the global reset
  ebm_out_stage #(
    .DATA_W(DATA_W),
    .WMODE(A_WMODE),
    .OUT_REG(A_OUT_REG),
    .RST_STYLE(A_RST_STYLE)
  ) u_out_a (
    .clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .port_rst_in(port_a_output_reset_in),
    .gsr_n_in(global_reset_n_in),
    .acc_in(st_q.a.ctl.en),
    .wr_in(st_q.a.ctl.we),
    .wdata_in(st_q.a.wdata),
    .old_in(rd_a),
    .dout_out(port_a_rdata_out)
  );

  // port b output stage
  ebm_out_stage #(
    .DATA_W(DATA_W),
    .WMODE(B_WMODE),
    .OUT_REG(B_OUT_REG),
    .RST_STYLE(B_RST_STYLE)
  ) u_out_b (
    .clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .port_rst_in(port_b_output_reset_in),
    .gsr_n_in(global_reset_n_in),
    .acc_in(st_q.b.ctl.en),
    .wr_in(st_q.b.ctl.we),
    .wdata_in(st_q.b.wdata),
    .old_in(rd_b),
    .dout_out(port_b_rdata_out)
  );

  // helper: no output reset of either kind on port a or b
  logic a_quiet; // port a free of output resets
  logic b_quiet; // port b free of output resets
  assign a_quiet = ~port_a_output_reset_in & global_reset_n_in;
  assign b_quiet = ~port_b_output_reset_in & global_reset_n_in;

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_b_in);

  // configured shape fits the block
  shape_fits_a: assert property (DATA_W * DEPTH <= `EBM_CAPACITY_BITS)
    else $error("port shape exceeds block capacity");

  // request lands in the input registers one edge later
  input_capture_a: assert property (
    port_a_en_in |=> st_q.a.ctl.en && st_q.a.addr == $past(port_a_addr_in) &&
                     st_q.a.wdata == $past(port_a_wdata_in))
    else $error("port a request not captured");

  // bypassed output: read word one edge after capture
  read_direct_a: assert property (
    (!A_OUT_REG && st_q.a.ctl.en && !st_q.a.ctl.we && a_quiet)
      ##1 a_quiet |-> port_a_rdata_out == $past(rd_a))
    else $error("port a direct read word wrong");

  // registered output: read word two edges after capture
  read_registered_a: assert property (
    (A_OUT_REG && st_q.a.ctl.en && !st_q.a.ctl.we && a_quiet)
      ##1 a_quiet [*2] |-> port_a_rdata_out == $past(rd_a, 2))
    else $error("port a registered read word wrong");

  // registered output on port b, same extra cycle
  read_registered_b_a: assert property (
    (B_OUT_REG && st_q.b.ctl.en && !st_q.b.ctl.we && b_quiet)
      ##1 b_quiet [*2] |-> port_b_rdata_out == $past(rd_b, 2))
    else $error("port b registered read word wrong");

  // normal mode: a write leaves the output alone
  normal_hold_a: assert property (
    (A_WMODE == EBM_WM_NORMAL && !A_OUT_REG && st_q.a.ctl.we && a_quiet)
      ##1 a_quiet |-> $stable(port_a_rdata_out))
    else $error("port a output moved on a normal write");

  // write-through: the written word appears on port a
  write_through_a: assert property (
    (A_WMODE == EBM_WM_THROUGH && !A_OUT_REG && st_q.a.ctl.we && a_quiet)
      ##1 a_quiet |-> port_a_rdata_out == $past(st_q.a.wdata))
    else $error("port a write-through word wrong");

  // read-before-write: old word appears while the new one is stored
  read_before_write_a: assert property (
    (A_WMODE == EBM_WM_RBW && ebm_rbw_ok(DATA_W) && !A_OUT_REG &&
     st_q.a.ctl.we && a_quiet && !(st_q.b.ctl.we && st_q.b.addr == st_q.a.addr))
      ##1 a_quiet |->
      port_a_rdata_out == $past(rd_a) && mem[$past(st_q.a.addr)] == $past(st_q.a.wdata))
    else $error("port a read-before-write word wrong");

  // read-before-write on port b, old word straight out
  rbw_direct_b_a: assert property (
    (B_WMODE == EBM_WM_RBW && ebm_rbw_ok(DATA_W) && !B_OUT_REG &&
     st_q.b.ctl.we && b_quiet) ##1 b_quiet |-> port_b_rdata_out == $past(rd_b))
    else $error("port b read-before-write word wrong");

  // read-before-write on port b, old word behind the output register
  rbw_registered_b_a: assert property (
    (B_WMODE == EBM_WM_RBW && ebm_rbw_ok(DATA_W) && B_OUT_REG &&
     st_q.b.ctl.we && b_quiet) ##1 b_quiet [*2] |-> port_b_rdata_out == $past(rd_b, 2))
    else $error("port b registered read-before-write word wrong");

  // own output reset clears port a by the next edge
  port_clear_a: assert property (
    port_a_output_reset_in |=> port_a_rdata_out == `EBM_OUT_CLR_VAL)
    else $error("port a output not cleared");

  // own output reset clears port b by the next edge
  port_clear_b_a: assert property (
    port_b_output_reset_in |=> port_b_rdata_out == `EBM_OUT_CLR_VAL)
    else $error("port b output not cleared");

  // port a reset leaves an idle port b untouched
  port_isolate_a: assert property (
    (port_a_output_reset_in && b_quiet && !st_q.b.ctl.en && !B_OUT_REG)
      ##1 b_quiet |-> $stable(port_b_rdata_out))
    else $error("port a reset disturbed port b");

  // port a reset does not change the array word port b reads
  array_kept_a: assert property (
    (port_a_output_reset_in && !st_q.a.ctl.we && !st_q.b.ctl.we) |=>
      mem[$past(st_q.b.addr)] == $past(rd_b))
    else $error("array changed under output reset");

  // global reset clears both ports together
  global_clear_a: assert property (
    !global_reset_n_in |=> port_a_rdata_out == `EBM_OUT_CLR_VAL &&
                           port_b_rdata_out == `EBM_OUT_CLR_VAL)
    else $error("global reset left an output set");

  // main scenarios
  read_seen_c: cover property (st_q.a.ctl.en && !st_q.a.ctl.we ##1 a_quiet);
  write_seen_c: cover property (st_q.a.ctl.we ##1 st_q.b.ctl.en && !st_q.b.ctl.we);
  port_reset_c: cover property (port_b_output_reset_in ##1 !port_b_output_reset_in);
  global_reset_c: cover property (!global_reset_n_in ##1 global_reset_n_in);
  rbw_seen_c: cover property (st_q.b.ctl.we ##1 st_q.a.ctl.en && !st_q.a.ctl.we);
endmodule : ebm_top
`default_nettype wire

// >>> dv/ebm_fabric.sv
// fabric-side user logic that drives the strobes, address and data of both memory ports
// assumes the bench calls drive once per cycle and samples read data itself
`timescale 1ns/1ps
`default_nettype none
module ebm_fabric
  import ebm_pkg::*;
#(
  parameter int AW = 10,
  parameter int DW = 18
) (
  input wire logic clk_in, // port clock
  output var ebm_ctl_t a_ctl_out, // port a strobes
  output logic [AW-1:0] a_addr_out, // port a address
  output logic [DW-1:0] a_data_out, // port a write data
  output var ebm_ctl_t b_ctl_out, // port b strobes
  output logic [AW-1:0] b_addr_out, // port b address
  output logic [DW-1:0] b_data_out // port b write data
);
  // quiet bus at time zero; modes stay fixed by the instance parameters
  initial begin
    a_ctl_out = '0;
    b_ctl_out = '0;
    a_addr_out = '0;
    b_addr_out = '0;
    a_data_out = '0;
    b_data_out = '0;
  end
  // one access per port, launched 1 ns after the edge and held for the cycle
  task automatic drive(input ebm_ctl_t ac, input logic [AW-1:0] aa, input logic [DW-1:0] ad,
                       input ebm_ctl_t bc, input logic [AW-1:0] ba, input logic [DW-1:0] bd);
    @(posedge clk_in);
    #1;
    a_ctl_out = ac;
    b_ctl_out = bc;
    // idle ports toggle address and data so stale values never look valid
    a_addr_out = ac.en ? aa : ~a_addr_out;
    a_data_out = ac.en ? ad : ~a_data_out;
    b_addr_out = bc.en ? ba : ~b_addr_out;
    b_data_out = bc.en ? bd : ~b_data_out;
  endtask : drive
endmodule : ebm_fabric
`default_nettype wire

// >>> dv/test_block_ram_port_behaviour.sv
// self-checking bench: port a write-through, port b read-before-write with output register
// and async reset; a second instance checks normal mode on port a
`timescale 1ns/1ps
`default_nettype none
module test_block_ram_port_behaviour
  import ebm_pkg::*;
;
  logic sys_clk_in; // system clock
  logic rst_b_in; // system reset, low
  logic gsr_n; // global output reset, low
  logic rst_a; // port a output reset
  logic rst_b; // port b output reset
  ebm_ctl_t a_ctl, b_ctl; // strobes from the fabric model
  logic [9:0] a_addr, b_addr; // addresses
  logic [17:0] a_wd, b_wd, a_rd, b_rd, n_rd; // data buses
  int err_total = 0; // mismatches
  int compares = 0; // comparisons made
  int cycles = 0; // timeout count
  localparam ebm_ctl_t RD = 2'h2; // read strobe
  localparam ebm_ctl_t WR = 2'h3; // write strobe
  localparam ebm_ctl_t IDLE = 2'h0; // no access
  localparam logic [17:0] D1 = 18'h2A5C3; // first stored word
  localparam logic [17:0] D2 = 18'h15A3C; // second stored word
  // main memory under test
  ebm_top #(.A_WMODE(EBM_WM_THROUGH), .B_WMODE(EBM_WM_RBW), .B_OUT_REG(1'b1),
            .B_RST_STYLE(EBM_RST_ASYNC)) DUT (
    .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .global_reset_n_in(gsr_n),
    .port_a_en_in(a_ctl.en), .port_a_we_in(a_ctl.we), .port_a_addr_in(a_addr),
    .port_a_wdata_in(a_wd), .port_a_output_reset_in(rst_a), .port_a_rdata_out(a_rd),
    .port_b_en_in(b_ctl.en), .port_b_we_in(b_ctl.we), .port_b_addr_in(b_addr),
    .port_b_wdata_in(b_wd), .port_b_output_reset_in(rst_b), .port_b_rdata_out(b_rd));
  // twin with default normal mode, same stimulus
  ebm_top DUT2 (
    .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .global_reset_n_in(gsr_n),
    .port_a_en_in(a_ctl.en), .port_a_we_in(a_ctl.we), .port_a_addr_in(a_addr),
    .port_a_wdata_in(a_wd), .port_a_output_reset_in(rst_a), .port_a_rdata_out(n_rd),
    .port_b_en_in(b_ctl.en), .port_b_we_in(b_ctl.we), .port_b_addr_in(b_addr),
    .port_b_wdata_in(b_wd), .port_b_output_reset_in(rst_b), .port_b_rdata_out());
  // fabric user logic on the far side
  ebm_fabric u_fab (.clk_in(sys_clk_in), .a_ctl_out(a_ctl), .a_addr_out(a_addr),
    .a_data_out(a_wd), .b_ctl_out(b_ctl), .b_addr_out(b_addr), .b_data_out(b_wd));
  // clock, 5 ns period
  initial begin
    sys_clk_in = 1'b0;
    forever #2.5 sys_clk_in = ~sys_clk_in;
  end
  // hang guard
  always @(posedge sys_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 1000) begin
      err_total = err_total + 1;
      end_sim();
    end
  end
  // verdict and stop
  task automatic end_sim();
    if (err_total == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim
  // compare one read word
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    compares = compares + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("[ERR] %0t read data %h expected %h", $time, got, exp);
    end
  endtask : chk
  // let n edges pass, then settle 1 ns
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask : step
  // a writes through, b reads the same word back through its extra register
  task automatic t_through();
    u_fab.drive(WR, 10'h005, D1, IDLE, '0, '0);
    u_fab.drive(IDLE, '0, '0, RD, 10'h005, '0);
    u_fab.drive(IDLE, '0, '0, IDLE, '0, '0);
    chk(a_rd, D1);
    chk(n_rd, 18'h00000);
    chk(b_rd, 18'h00000);
    step(1);
    chk(b_rd, 18'h00000);
    step(1);
    chk(b_rd, D1);
  endtask : t_through
  // b first shows another word, then overwrites and shows the old word; a reads the new one
  task automatic t_rbw();
    u_fab.drive(WR, 10'h00A, D2, IDLE, '0, '0);
    u_fab.drive(IDLE, '0, '0, RD, 10'h00A, '0);
    u_fab.drive(IDLE, '0, '0, WR, 10'h005, D2);
    u_fab.drive(RD, 10'h005, '0, IDLE, '0, '0);
    u_fab.drive(IDLE, '0, '0, IDLE, '0, '0);
    step(1);
    chk(a_rd, D2);
    chk(n_rd, D2);
    chk(b_rd, D1);
  endtask : t_rbw
  // per-port clears: a on the edge, b at once, array kept
  task automatic t_port_reset();
    rst_a = 1'b1;
    #1;
    chk(a_rd, D2);
    step(1);
    chk(a_rd, 18'h00000);
    chk(b_rd, D1);
    rst_a = 1'b0;
    // one quiet cycle between the a clear and the b clear; port b was checked untouched just above
    step(1);
    rst_b = 1'b1;
    #1;
    chk(b_rd, 18'h00000);
    step(1);
    rst_b = 1'b0;
    u_fab.drive(RD, 10'h005, '0, RD, 10'h005, '0);
    u_fab.drive(IDLE, '0, '0, IDLE, '0, '0);
    step(1);
    chk(a_rd, D2);
    step(1);
    chk(b_rd, D2);
  endtask : t_port_reset
  // global clear reaches both ports
  task automatic t_global();
    gsr_n = 1'b0;
    #1;
    chk(b_rd, 18'h00000);
    chk(a_rd, D2);
    step(1);
    chk(a_rd, 18'h00000);
    gsr_n = 1'b1;
  endtask : t_global
  // main sequence
  initial begin
    rst_b_in = 1'b0;
    gsr_n = 1'b1;
    rst_a = 1'b0;
    rst_b = 1'b0;
    step(10);
    rst_b_in = 1'b1;
    t_through();
    t_rbw();
    t_port_reset();
    t_global();
    step(2);
    end_sim();
  end
endmodule : test_block_ram_port_behaviour
`default_nettype wire
